// >>> logic/ubm_cfg.svh
// Purpose: Constants for the endpoint buffer manager.
// Assumes: Included by bare name from the package and the modules.
// Notes:   Page pool size is a plain default, not a documented figure.
`ifndef UBM_CFG_SVH
`define UBM_CFG_SVH
`define UBM_PN_W       8
`define UBM_TX_EP      16
`define UBM_TX_EP_W    4
`define UBM_TX_DEPTH   5
`define UBM_TX_CNT_W   3
`define UBM_RX_EP      32
`define UBM_RX_EP_W    5
`define UBM_QUOTA_W    5
`define UBM_QUOTA_RST  5'h00
`define UBM_PAGES      64
`define UBM_PAGE_W     8
`endif

// >>> logic/ubm_pkg.sv
// Purpose: Types shared by the endpoint buffer manager files.
// Assumes: ubm_cfg.svh gives the widths.
// Notes:   Enumerations carry no explicit codes.
`default_nettype none
`include "ubm_cfg.svh"
package ubm_pkg;
    typedef enum logic [1:0] {MMU_ENQUEUE, MMU_PACKET_FREE, MMU_QUEUE_RESET} mmu_cmd_t;
    typedef enum logic [1:0] {QUOTA_CLEAR_DISABLE, QUOTA_INCREMENT, QUOTA_ENABLE, QUOTA_SNAPSHOT} quota_cmd_t;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} handshake_t;
    typedef struct packed {
        mmu_cmd_t                 cmd;
        logic [`UBM_TX_EP_W-1:0]  ep;
        logic [`UBM_PN_W-1:0]     pn;
    } mmu_req_t;
    typedef struct packed {
        quota_cmd_t               cmd;
        logic [`UBM_RX_EP_W-1:0]  ep;
    } quota_req_t;
    typedef struct packed {
        logic                     enabled;
        logic [`UBM_QUOTA_W-1:0]  count;
    } quota_stat_t;
    typedef struct packed {
        logic [`UBM_RX_EP_W-1:0]  ep;
        logic                     crc_ok;
        logic                     halted;
        logic                     toggle_ok;
        logic                     iso;
    } rx_pkt_t;
endpackage
`default_nettype wire

// >>> logic/quota_counter.sv
// Purpose: One saturating receive quota counter with its enable bit.
// Assumes: At most one firmware command per cycle.
// Notes:   A clear wins over a same-cycle hardware decrement; an increment and a decrement in one cycle cancel out.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module quota_counter #(
    parameter int W = `UBM_QUOTA_W
) (
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         clr_dis_in,
    input  wire logic         inc_in,
    input  wire logic         en_in,
    input  wire logic         dec_in,
    output logic [W-1:0]      count_out,
    output logic              enabled_out
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         en_ff;
    logic         nxt_en;

    // Saturate at both ends so a stray step never wraps the limit.
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_en  = en_ff;
        if (clr_dis_in)
        begin
            nxt_cnt = '0;
            nxt_en  = 1'b0;
        end
        else if (inc_in && !dec_in && cnt_ff != {W{1'b1}})
            nxt_cnt = cnt_ff + 1'b1;
        else if (dec_in && !inc_in && cnt_ff != '0)
            nxt_cnt = cnt_ff - 1'b1;
        if (en_in)
            nxt_en = 1'b1;
    end

    // Limiting is off after reset; counting continues regardless.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_ff <= `UBM_QUOTA_RST;
            en_ff  <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            en_ff  <= nxt_en;
        end
    end

    assign count_out   = cnt_ff;
    assign enabled_out = en_ff;
endmodule
`default_nettype wire

// >>> logic/tx_queue_mem.sv
// Purpose: Storage for all transmit queue entries.
// Assumes: One write and one read per cycle.
// Notes:   Read data is registered; it appears one cycle after the read.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module tx_queue_mem #(
    parameter int WIDTH = `UBM_PN_W,
    parameter int WORDS = `UBM_TX_EP * `UBM_TX_DEPTH,
    parameter int AW    = $clog2(WORDS)
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             we_in,
    input  wire logic [AW-1:0]    waddr_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    input  wire logic             re_in,
    input  wire logic [AW-1:0]    raddr_in,
    output logic [WIDTH-1:0]      rdata_out
);
    logic [WIDTH-1:0] mem_ff [WORDS];
    logic [WIDTH-1:0] rdata_ff;

    // Array has no reset; entries are only read after being written.
    always_ff @(posedge clk_in)
    begin
        if (we_in)
            mem_ff[waddr_in] <= wdata_in;
    end

    // Registered read port.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_ff <= '0;
        else if (re_in)
            rdata_ff <= mem_ff[raddr_in];
    end

    assign rdata_out = rdata_ff;
endmodule
`default_nettype wire

// >>> logic/ep_buffer_mgr.sv
// Purpose: Transmit queue flush, receive quota and refusal flags.
// Assumes: Firmware issues at most one command of each kind per cycle.
// Notes:   Receive handshake is decided here and reported registered.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
module ep_buffer_mgr #(
    parameter int NUM_TX_EP = `UBM_TX_EP,
    parameter int TX_DEPTH  = `UBM_TX_DEPTH,
    parameter int NUM_PAGES = `UBM_PAGES
) (
    input  wire logic                      clk_in,
    input  wire logic                      rst_b_in,
    input  wire logic                      mmu_cmd_valid_in,
    input  var  ubm_pkg::mmu_req_t         mmu_command_reg_in,
    input  wire logic                      tx_pop_req_in,
    input  wire logic [`UBM_TX_EP_W-1:0]   tx_endpoint_select_in,
    input  wire logic                      page_alloc_in,
    input  wire logic                      refuse_all_rx_bit_in,
    input  wire logic                      quota_cmd_valid_in,
    input  var  ubm_pkg::quota_req_t       rx_quota_command_reg_in,
    input  wire logic                      rx_pkt_valid_in,
    input  var  ubm_pkg::rx_pkt_t          rx_pkt_in,
    input  wire logic                      serial_engine_in_nak_in,
    input  wire logic [`UBM_RX_EP_W-1:0]   serial_engine_in_ep_in,
    input  wire logic [`UBM_RX_EP-1:0]     in_nak_clear_in,
    input  wire logic [`UBM_RX_EP-1:0]     out_nak_clear_in,
    output logic                           tx_pop_valid_out,
    output logic                           tx_pop_empty_out,
    output logic [`UBM_PN_W-1:0]           tx_pop_pn_out,
    output logic [NUM_TX_EP-1:0]           tx_empty_out,
    output logic [NUM_TX_EP-1:0]           tx_full_out,
    output logic [`UBM_PAGE_W-1:0]         free_page_count_out,
    output var  ubm_pkg::quota_stat_t      rx_quota_status_reg_out,
    output logic                           hs_valid_out,
    output var  ubm_pkg::handshake_t       hs_out,
    output logic                           rx_accept_out,
    output logic [`UBM_RX_EP-1:0]          in_nak_flags_out,
    output logic [`UBM_RX_EP-1:0]          out_nak_flags_out
);
    localparam int WORDS = NUM_TX_EP * TX_DEPTH;
    localparam int AW    = $clog2(WORDS);
    localparam int CW    = `UBM_TX_CNT_W;

    // All checks below belong to the one clock and are off during reset.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Refuse sizes the pointers and page counter cannot hold.
    if (NUM_TX_EP > (1 << `UBM_TX_EP_W) || TX_DEPTH < 1 || TX_DEPTH >= (1 << CW)
        || NUM_PAGES < 1 || NUM_PAGES >= (1 << `UBM_PAGE_W))
    begin : g_bad_params
        $error("ep_buffer_mgr: unsupported parameter values");
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit queues.
    logic [CW-1:0]            head_ff  [NUM_TX_EP];
    logic [CW-1:0]            cnt_ff   [NUM_TX_EP];
    logic [CW-1:0]            nxt_head [NUM_TX_EP];
    logic [CW-1:0]            nxt_cnt  [NUM_TX_EP];
    logic [NUM_TX_EP-1:0]     empty_ff;
    logic [NUM_TX_EP-1:0]     full_ff;
    logic [NUM_TX_EP-1:0]     nxt_empty;
    logic [NUM_TX_EP-1:0]     nxt_full;
    logic                     pop_valid_ff;
    logic                     pop_empty_ff;
    logic                     nxt_pop_valid;
    logic                     nxt_pop_empty;
    logic                     mem_we;
    logic                     mem_re;
    logic [AW-1:0]            mem_waddr;
    logic [AW-1:0]            mem_raddr;
    logic [`UBM_PN_W-1:0]     pop_pn;

    // Slot address of entry idx in queue ep, wrapping inside that queue.
    function automatic logic [AW-1:0] slot(input int ep, input int idx);
        int w;
        w = (idx >= TX_DEPTH) ? idx - TX_DEPTH : idx;
        return AW'(ep * TX_DEPTH + w);
    endfunction

    // Firmware pop and firmware enqueue may meet on one queue in a cycle.
    always_comb
    begin
        int ep;
        int sel;
        ep            = 0;
        sel           = int'(tx_endpoint_select_in);
        mem_we        = 1'b0;
        mem_re        = 1'b0;
        mem_waddr     = '0;
        mem_raddr     = '0;
        nxt_pop_valid = tx_pop_req_in;
        nxt_pop_empty = 1'b0;
        for (int i = 0; i < NUM_TX_EP; i++)
        begin
            nxt_head[i] = head_ff[i];
            nxt_cnt[i]  = cnt_ff[i];
        end
        if (tx_pop_req_in && sel < NUM_TX_EP)
        begin
            if (cnt_ff[sel] != '0)
            begin
                mem_re        = 1'b1;
                mem_raddr     = slot(sel, int'(head_ff[sel]));
                nxt_head[sel] = (int'(head_ff[sel]) == TX_DEPTH - 1) ? '0 : head_ff[sel] + 1'b1;
                nxt_cnt[sel]  = cnt_ff[sel] - 1'b1;
            end
            else
                nxt_pop_empty = 1'b1;
        end
        if (mmu_cmd_valid_in)
        begin
            ep = int'(mmu_command_reg_in.ep);
            if (ep < NUM_TX_EP)
            begin
                if (mmu_command_reg_in.cmd == ubm_pkg::MMU_ENQUEUE && int'(nxt_cnt[ep]) < TX_DEPTH)
                begin
                    mem_we      = 1'b1;
                    mem_waddr   = slot(ep, int'(nxt_head[ep]) + int'(nxt_cnt[ep]));
                    nxt_cnt[ep] = nxt_cnt[ep] + 1'b1;
                end
                else if (mmu_command_reg_in.cmd == ubm_pkg::MMU_QUEUE_RESET)
                begin
                    nxt_cnt[ep]  = '0;
                    nxt_head[ep] = '0;
                end
            end
        end
        for (int i = 0; i < NUM_TX_EP; i++)
        begin
            nxt_empty[i] = (nxt_cnt[i] == '0);
            nxt_full[i]  = (int'(nxt_cnt[i]) == TX_DEPTH);
        end
    end

    // Queue state registers.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            for (int i = 0; i < NUM_TX_EP; i++)
            begin
                head_ff[i] <= '0;
                cnt_ff[i]  <= '0;
            end
            empty_ff     <= '1;
            full_ff      <= '0;
            pop_valid_ff <= 1'b0;
            pop_empty_ff <= 1'b0;
        end
        else
        begin
            head_ff      <= nxt_head;
            cnt_ff       <= nxt_cnt;
            empty_ff     <= nxt_empty;
            full_ff      <= nxt_full;
            pop_valid_ff <= nxt_pop_valid;
            pop_empty_ff <= nxt_pop_empty;
        end
    end

    tx_queue_mem #(
        .WIDTH (`UBM_PN_W),
        .WORDS (WORDS),
        .AW    (AW)
    ) u_mem (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .we_in     (mem_we),
        .waddr_in  (mem_waddr),
        .wdata_in  (mmu_command_reg_in.pn),
        .re_in     (mem_re),
        .raddr_in  (mem_raddr),
        .rdata_out (pop_pn)
    );

    //////////////////////////////////////////////////////////////////////////
    // Page pool. A queue reset frees nothing; only the free command does.
    logic [`UBM_PAGE_W-1:0] pages_ff;
    logic [`UBM_PAGE_W-1:0] nxt_pages;
    logic                   do_free;

    // Allocation and free in one cycle cancel out.
    always_comb
    begin
        do_free   = mmu_cmd_valid_in && mmu_command_reg_in.cmd == ubm_pkg::MMU_PACKET_FREE;
        nxt_pages = pages_ff;
        if (do_free && !page_alloc_in && int'(pages_ff) < NUM_PAGES)
            nxt_pages = pages_ff + 1'b1;
        else if (page_alloc_in && !do_free && pages_ff != '0)
            nxt_pages = pages_ff - 1'b1;
    end

    // Pool starts full.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pages_ff <= `UBM_PAGE_W'(NUM_PAGES);
        else
            pages_ff <= nxt_pages;
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive quota counters, one per endpoint.
    logic [`UBM_QUOTA_W-1:0] q_cnt [`UBM_RX_EP];
    logic [`UBM_RX_EP-1:0]   q_en;
    logic [`UBM_RX_EP-1:0]   q_dec;
    ubm_pkg::quota_stat_t    stat_ff;
    ubm_pkg::quota_stat_t    nxt_stat;

    for (genvar g = 0; g < `UBM_RX_EP; g++)
    begin : g_quota
        logic hit;
        assign hit = quota_cmd_valid_in && int'(rx_quota_command_reg_in.ep) == g;
        quota_counter #(
            .W (`UBM_QUOTA_W)
        ) u_q (
            .clk_in      (clk_in),
            .rst_b_in    (rst_b_in),
            .clr_dis_in  (hit && rx_quota_command_reg_in.cmd == ubm_pkg::QUOTA_CLEAR_DISABLE),
            .inc_in      (hit && rx_quota_command_reg_in.cmd == ubm_pkg::QUOTA_INCREMENT),
            .en_in       (hit && rx_quota_command_reg_in.cmd == ubm_pkg::QUOTA_ENABLE),
            .dec_in      (q_dec[g]),
            .count_out   (q_cnt[g]),
            .enabled_out (q_en[g])
        );
    end

    // Snapshot latches count and enable of the named endpoint.
    always_comb
    begin
        nxt_stat = stat_ff;
        if (quota_cmd_valid_in && rx_quota_command_reg_in.cmd == ubm_pkg::QUOTA_SNAPSHOT)
        begin
            nxt_stat.count   = q_cnt[rx_quota_command_reg_in.ep];
            nxt_stat.enabled = q_en[rx_quota_command_reg_in.ep];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Handshake after an OUT data packet; first matching case wins.
    ubm_pkg::handshake_t   hs_ff;
    ubm_pkg::handshake_t   nxt_hs;
    logic                  hs_valid_ff;
    logic                  accept_ff;
    logic                  nxt_accept;
    logic                  blocked;
    logic [`UBM_RX_EP-1:0] in_nak_ff;
    logic [`UBM_RX_EP-1:0] out_nak_ff;
    logic [`UBM_RX_EP-1:0] nxt_in_nak;
    logic [`UBM_RX_EP-1:0] nxt_out_nak;

    always_comb
    begin
        blocked    = (q_en[rx_pkt_in.ep] && q_cnt[rx_pkt_in.ep] == '0)
                     || refuse_all_rx_bit_in || pages_ff == '0;
        nxt_hs     = ubm_pkg::HS_NONE;
        nxt_accept = 1'b0;
        q_dec      = '0;
        if (rx_pkt_valid_in && rx_pkt_in.crc_ok)
        begin
            if (rx_pkt_in.iso)
                nxt_accept = !blocked;
            else if (rx_pkt_in.halted)
                nxt_hs = ubm_pkg::HS_STALL;
            else if (!rx_pkt_in.toggle_ok)
                nxt_hs = ubm_pkg::HS_ACK;
            else if (blocked)
                nxt_hs = ubm_pkg::HS_NAK;
            else
            begin
                nxt_hs     = ubm_pkg::HS_ACK;
                nxt_accept = 1'b1;
            end
            q_dec[rx_pkt_in.ep] = nxt_accept;
        end
        // A set in the clearing cycle wins over the clear.
        nxt_in_nak  = in_nak_ff & ~in_nak_clear_in;
        nxt_out_nak = out_nak_ff & ~out_nak_clear_in;
        if (serial_engine_in_nak_in)
            nxt_in_nak[serial_engine_in_ep_in] = 1'b1;
        if (nxt_hs == ubm_pkg::HS_NAK)
            nxt_out_nak[rx_pkt_in.ep] = 1'b1;
    end

    // Receive side registers.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            stat_ff     <= '0;
            hs_ff       <= ubm_pkg::HS_NONE;
            hs_valid_ff <= 1'b0;
            accept_ff   <= 1'b0;
            in_nak_ff   <= '0;
            out_nak_ff  <= '0;
        end
        else
        begin
            stat_ff     <= nxt_stat;
            hs_ff       <= nxt_hs;
            hs_valid_ff <= rx_pkt_valid_in;
            accept_ff   <= nxt_accept;
            in_nak_ff   <= nxt_in_nak;
            out_nak_ff  <= nxt_out_nak;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign tx_pop_valid_out        = pop_valid_ff;
    assign tx_pop_empty_out        = pop_empty_ff;
    assign tx_pop_pn_out           = pop_pn;
    assign tx_empty_out            = empty_ff;
    assign tx_full_out             = full_ff;
    assign free_page_count_out     = pages_ff;
    assign rx_quota_status_reg_out = stat_ff;
    assign hs_valid_out            = hs_valid_ff;
    assign hs_out                  = hs_ff;
    assign rx_accept_out           = accept_ff;
    assign in_nak_flags_out        = in_nak_ff;
    assign out_nak_flags_out       = out_nak_ff;

    //////////////////////////////////////////////////////////////////////////
    // Checks.
    a_reset_empties: assert property (mmu_cmd_valid_in && mmu_command_reg_in.cmd == ubm_pkg::MMU_QUEUE_RESET
        && !tx_pop_req_in && int'(mmu_command_reg_in.ep) < NUM_TX_EP |=> tx_empty_out[$past(mmu_command_reg_in.ep)]
        && (free_page_count_out == $past(free_page_count_out) || $past(page_alloc_in)))
        else $error("queue reset did not empty queue or changed pages");
    a_pop_empty_flag: assert property (tx_pop_req_in && int'(tx_endpoint_select_in) < NUM_TX_EP
        && tx_empty_out[tx_endpoint_select_in] |=> tx_pop_valid_out && tx_pop_empty_out)
        else $error("pop of empty queue not flagged");
    a_quota_naks: assert property (rx_pkt_valid_in && rx_pkt_in.crc_ok && !rx_pkt_in.iso
        && !rx_pkt_in.halted && rx_pkt_in.toggle_ok && q_en[rx_pkt_in.ep] && q_cnt[rx_pkt_in.ep] == '0
        |=> hs_valid_out && hs_out == ubm_pkg::HS_NAK && !rx_accept_out)
        else $error("exhausted quota not refused");
    a_refuse_all: assert property (rx_pkt_valid_in && refuse_all_rx_bit_in |=> !rx_accept_out)
        else $error("refuse-all bit ignored");
    a_bad_crc_quiet: assert property (rx_pkt_valid_in && !rx_pkt_in.crc_ok |=> hs_out == ubm_pkg::HS_NONE)
        else $error("handshake sent for corrupted data");
    a_stall_halted: assert property (rx_pkt_valid_in && rx_pkt_in.crc_ok && !rx_pkt_in.iso
        && rx_pkt_in.halted |=> hs_out == ubm_pkg::HS_STALL) else $error("halted endpoint not stalled");
    a_accept_dec: assert property (rx_pkt_valid_in && !quota_cmd_valid_in && nxt_accept
        && q_cnt[rx_pkt_in.ep] != '0 |=> q_cnt[$past(rx_pkt_in.ep)] == $past(q_cnt[rx_pkt_in.ep]) - 1'b1)
        else $error("accepted packet did not lower quota");
    a_in_nak_sets: assert property (serial_engine_in_nak_in
        |=> in_nak_flags_out[$past(serial_engine_in_ep_in)]) else $error("IN refusal flag not set");
    a_out_nak_sets: assert property (nxt_hs == ubm_pkg::HS_NAK |=> out_nak_flags_out[$past(rx_pkt_in.ep)])
        else $error("OUT refusal flag not set");
    a_flag_hold: assert property (!serial_engine_in_nak_in && in_nak_clear_in == '0
        |=> $stable(in_nak_flags_out)) else $error("IN refusal flag changed without cause");
    a_quota_snap: assert property (quota_cmd_valid_in
        && rx_quota_command_reg_in.cmd == ubm_pkg::QUOTA_SNAPSHOT
        |=> rx_quota_status_reg_out.count == $past(q_cnt[rx_quota_command_reg_in.ep]))
        else $error("snapshot did not latch count");

    c_pop_data: cover property (tx_pop_req_in ##1 tx_pop_valid_out && !tx_pop_empty_out);
    c_quota_nak: cover property (hs_valid_out && hs_out == ubm_pkg::HS_NAK);
    c_accept: cover property (rx_accept_out);
    c_flag_clear: cover property (in_nak_flags_out != '0 ##1 in_nak_flags_out == '0);
endmodule
`default_nettype wire

// >>> verification/serial_engine_model.sv
// Purpose: Serial engine stand-in presenting received packets and IN refusals.
// Assumes: The bench calls its tasks; each pulse lasts one cycle.
// Notes:   Packet fields are scrambled once stale so no old value looks valid.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module serial_engine_model (
    input  wire logic                    clk_in,
    output logic                         rx_pkt_valid_out,
    output var  ubm_pkg::rx_pkt_t        rx_pkt_out,
    output logic                         in_nak_out,
    output logic [`UBM_RX_EP_W-1:0]      in_ep_out
);
    // Quiet lines from time zero.
    initial
    begin
        rx_pkt_valid_out = 1'b0;
        rx_pkt_out       = '0;
        in_nak_out       = 1'b0;
        in_ep_out        = '0;
    end
    // One received packet, which lowers that endpoint's quota only if accepted.
    task automatic send(input ubm_pkg::rx_pkt_t p);
        @(negedge clk_in);
        rx_pkt_out       = p;
        rx_pkt_valid_out = 1'b1;
        @(negedge clk_in);
        rx_pkt_valid_out = 1'b0;
        rx_pkt_out       = ~p;
    endtask
    // IN refusal; never aimed at an endpoint whose queue is being flushed.
    task automatic nak_in(input logic [`UBM_RX_EP_W-1:0] ep);
        @(negedge clk_in);
        in_ep_out  = ep;
        in_nak_out = 1'b1;
        @(negedge clk_in);
        in_nak_out = 1'b0;
        in_ep_out  = ~ep;
    endtask
endmodule
`default_nettype wire

// >>> verification/ep_buffer_mgr_tb.sv
// Purpose: Self-checking bench for the endpoint buffer manager.
// Assumes: Inputs change on the falling edge; outputs are read there.
// Notes:   Latencies are the fixed one cycle of the design.
`timescale 1ns/1ps
`default_nettype none
`include "ubm_cfg.svh"
module ep_buffer_mgr_tb;
    logic                 clk, rst_b, mmu_v, pop_req, alloc, refuse, q_v, rx_v, in_nak, pop_v, pop_e, hs_v, acc;
    logic [3:0]           sel;
    logic [4:0]           in_ep;
    logic [7:0]           pop_pn, free_pg;
    logic [15:0]          tx_empty, tx_full;
    logic [31:0]          in_clr, out_clr, in_fl, out_fl;
    ubm_pkg::mmu_req_t    mmu_req;
    ubm_pkg::quota_req_t  q_req;
    ubm_pkg::rx_pkt_t     pkt;
    ubm_pkg::quota_stat_t q_st;
    ubm_pkg::handshake_t  hs;
    int                   mismatches, n_compared, i;
    // Clock of 4 ns.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    ep_buffer_mgr ep_buffer_mgr_inst (.clk_in(clk), .rst_b_in(rst_b), .mmu_cmd_valid_in(mmu_v),
        .mmu_command_reg_in(mmu_req), .tx_pop_req_in(pop_req), .tx_endpoint_select_in(sel), .page_alloc_in(alloc),
        .refuse_all_rx_bit_in(refuse), .quota_cmd_valid_in(q_v), .rx_quota_command_reg_in(q_req),
        .rx_pkt_valid_in(rx_v), .rx_pkt_in(pkt), .serial_engine_in_nak_in(in_nak), .serial_engine_in_ep_in(in_ep),
        .in_nak_clear_in(in_clr), .out_nak_clear_in(out_clr), .tx_pop_valid_out(pop_v), .tx_pop_empty_out(pop_e),
        .tx_pop_pn_out(pop_pn), .tx_empty_out(tx_empty), .tx_full_out(tx_full), .free_page_count_out(free_pg),
        .rx_quota_status_reg_out(q_st), .hs_valid_out(hs_v), .hs_out(hs), .rx_accept_out(acc),
        .in_nak_flags_out(in_fl), .out_nak_flags_out(out_fl));
    serial_engine_model serial_engine_model_inst (.clk_in(clk), .rx_pkt_valid_out(rx_v), .rx_pkt_out(pkt),
        .in_nak_out(in_nak), .in_ep_out(in_ep));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask
    task automatic mmu(input ubm_pkg::mmu_cmd_t c, input logic [3:0] ep, input logic [7:0] pn);
        @(negedge clk);
        mmu_req = '{c, ep, pn};
        mmu_v   = 1'b1;
        @(negedge clk);
        mmu_v   = 1'b0;
    endtask
    task automatic quota(input ubm_pkg::quota_cmd_t c, input logic [4:0] ep);
        @(negedge clk);
        q_req = '{c, ep};
        q_v   = 1'b1;
        @(negedge clk);
        q_v   = 1'b0;
    endtask
    task automatic pop(input logic [3:0] ep, input logic e, input logic [7:0] pn);
        @(negedge clk);
        sel     = ep;
        pop_req = 1'b1;
        @(negedge clk);
        pop_req = 1'b0;
        cmp("pop valid", 32'h1, pop_v);
        cmp("pop empty", e, pop_e);
        if (!e)
            cmp("pop number", pn, pop_pn);
    endtask
    // Flags are {crc_ok, halted, toggle_ok, iso}.
    task automatic rx(input logic [4:0] ep, input logic [3:0] f, input ubm_pkg::handshake_t h, input logic a);
        serial_engine_model_inst.send({ep, f});
        cmp("hs valid", 32'h1, hs_v);
        cmp("handshake", h, hs);
        cmp("accept", a, acc);
    endtask
    task automatic clr(input logic [31:0] ic, input logic [31:0] oc);
        @(negedge clk);
        in_clr  = ic;
        out_clr = oc;
        @(negedge clk);
        in_clr  = '0;
        out_clr = '0;
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, queue flush, quota, handshakes, refusal flags.
    initial
    begin
        {rst_b, mmu_v, pop_req, alloc, refuse, q_v, sel, in_clr, out_clr, mmu_req, q_req} = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        cmp("empty", 32'hFFFF, tx_empty);
        cmp("free", 32'h40, free_pg);
        cmp("status", 32'h0, q_st);
        $display("reset test done");
        mmu(ubm_pkg::MMU_ENQUEUE, 4'h2, 8'h07);
        mmu(ubm_pkg::MMU_ENQUEUE, 4'h2, 8'h09);
        mmu(ubm_pkg::MMU_ENQUEUE, 4'h3, 8'h05);
        alloc = 1'b1;
        repeat (3) @(negedge clk);
        alloc = 1'b0;
        cmp("free", 32'h3D, free_pg);
        for (i = 0; i < 8 && tx_empty[2] !== 1'b1; i++)
        begin
            pop(4'h2, 1'b0, i ? 8'h09 : 8'h07);
            mmu(ubm_pkg::MMU_PACKET_FREE, 4'h2, pop_pn);
        end
        cmp("flush pops", 32'h2, i);
        mmu(ubm_pkg::MMU_QUEUE_RESET, 4'h2, 8'h00);
        mmu(ubm_pkg::MMU_ENQUEUE, 4'h2, 8'h11);
        mmu(ubm_pkg::MMU_QUEUE_RESET, 4'h3, 8'h00);
        cmp("empty", 32'hFFFB, tx_empty);
        cmp("free", 32'h3F, free_pg);
        pop(4'h2, 1'b0, 8'h11);
        pop(4'h2, 1'b1, 8'h00);
        repeat (5) mmu(ubm_pkg::MMU_ENQUEUE, 4'h4, 8'h20);
        cmp("full", 32'h10, tx_full);
        mmu(ubm_pkg::MMU_QUEUE_RESET, 4'h4, 8'h00);
        cmp("full", 32'h0, tx_full);
        $display("queue test done");
        rx(5'h1F, 4'hA, ubm_pkg::HS_ACK, 1'b1);
        quota(ubm_pkg::QUOTA_CLEAR_DISABLE, 5'h00);
        quota(ubm_pkg::QUOTA_INCREMENT, 5'h00);
        quota(ubm_pkg::QUOTA_ENABLE, 5'h00);
        quota(ubm_pkg::QUOTA_SNAPSHOT, 5'h00);
        cmp("status", 32'h21, q_st);
        rx(5'h00, 4'hA, ubm_pkg::HS_ACK, 1'b1);
        rx(5'h00, 4'hA, ubm_pkg::HS_NAK, 1'b0);
        rx(5'h00, 4'hB, ubm_pkg::HS_NONE, 1'b0);
        cmp("out flags", 32'h1, out_fl);
        clr(32'h0, 32'hFFFFFFFE);
        cmp("out flags", 32'h1, out_fl);
        clr(32'h0, 32'h1);
        cmp("out flags", 32'h0, out_fl);
        quota(ubm_pkg::QUOTA_CLEAR_DISABLE, 5'h00);
        rx(5'h00, 4'hA, ubm_pkg::HS_ACK, 1'b1);
        quota(ubm_pkg::QUOTA_SNAPSHOT, 5'h00);
        cmp("status", 32'h0, q_st);
        $display("quota test done");
        repeat (33) quota(ubm_pkg::QUOTA_INCREMENT, 5'h01);
        rx(5'h01, 4'h2, ubm_pkg::HS_NONE, 1'b0);
        rx(5'h01, 4'hE, ubm_pkg::HS_STALL, 1'b0);
        rx(5'h01, 4'h8, ubm_pkg::HS_ACK, 1'b0);
        quota(ubm_pkg::QUOTA_SNAPSHOT, 5'h01);
        cmp("status", 32'h1F, q_st);
        refuse = 1'b1;
        rx(5'h01, 4'hA, ubm_pkg::HS_NAK, 1'b0);
        refuse = 1'b0;
        serial_engine_model_inst.nak_in(5'h05);
        cmp("in flags", 32'h20, in_fl);
        clr(32'h20, 32'h0);
        cmp("in flags", 32'h0, in_fl);
        $display("handshake test done");
        give_verdict();
    end
endmodule
`default_nettype wire
